// >>> common/bms_pkg.sv
`default_nettype none

package bms_pkg;

	// ************************************************************
	// Clock and timebase
	// ************************************************************
	localparam int unsigned CLK_HZ       = 10_000_000;
	localparam int unsigned TICK_MS      = 100;
	localparam int unsigned TICK_CYCLES  = TICK_MS * (CLK_HZ / 1000);
	localparam int unsigned FLASH_HALF_MS = 500;
	localparam int unsigned FLASH_TICKS  = FLASH_HALF_MS / TICK_MS;

	// ************************************************************
	// Sequence times
	// ************************************************************
	localparam int unsigned CLOSE_DELAY_S   = 2;
	localparam int unsigned CLOSE_DELAY_TICKS = CLOSE_DELAY_S * 1000 / TICK_MS;
	localparam int unsigned YELLOW_S      = 2;
	localparam int unsigned YELLOW_TICKS  = YELLOW_S * 1000 / TICK_MS;
	localparam int unsigned HORN_S        = 10;
	localparam logic [7:0]  HORN_TICKS_RST = 8'(HORN_S * 1000 / TICK_MS);

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_HORN   = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;

	localparam int unsigned CTRL_RST_WIGWAG = 0;
	localparam int unsigned CTRL_WIGWAG_TL  = 1;
	localparam int unsigned CTRL_SPAN_BOTH  = 2;
	localparam int unsigned CTRL_MULTI_BAR  = 3;
	localparam logic [3:0]  CTRL_RST        = 4'h1;

	localparam int unsigned STAT_SIG_LSB   = 0;
	localparam int unsigned STAT_ACTIVE    = 2;
	localparam int unsigned STAT_CLOSE_REQ = 3;
	localparam int unsigned STAT_MODE_LSB  = 4;
	localparam int unsigned STAT_HORN      = 6;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {MODE_EMERG, MODE_TEST, MODE_LOCAL} bms_mode_t;
	typedef enum logic [1:0] {SIG_DARK, SIG_YELLOW, SIG_RED} bms_sig_t;

endpackage

`default_nettype wire

// >>> design/bms_sequencer.sv
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module bms_sequencer
	import bms_pkg::*;
#(
	parameter int unsigned NUM_STATIONS = 4,
	parameter int unsigned NUM_BARRIERS = 1,
	parameter int unsigned TICK_DIV     = TICK_CYCLES,
	parameter int unsigned FLASH_DIV    = FLASH_TICKS
) (
	input  wire logic                    i_clk,
	input  wire logic                    i_rst_n,
	// Register port
	input  wire logic [3:0]              i_addr,
	input  wire logic [31:0]             i_wdata,
	input  wire logic                    i_wr,
	input  wire logic                    i_rd,
	output logic [31:0]                  o_rdata,
	// Panels and field inputs
	input  wire logic [1:0]              i_mode_sel,
	input  wire logic [NUM_STATIONS-1:0] i_emergency_close_station,
	input  wire logic                    i_emergency_latch_clear,
	input  wire logic                    i_master_open,
	input  wire logic                    i_master_close,
	input  wire logic                    i_local_key,
	input  wire logic                    i_local_open,
	input  wire logic                    i_local_close,
	input  wire logic                    i_detector_entry,
	input  wire logic                    i_detector_exit,
	input  wire logic [NUM_BARRIERS-1:0] i_barrier_open,
	input  wire logic                    i_span_inhibit,
	// Field outputs
	output logic                         o_beacon_yellow,
	output logic                         o_beacon_red_a,
	output logic                         o_beacon_red_b,
	output logic                         o_pavement_red,
	output logic                         o_wigwag,
	output logic                         o_horn,
	output logic                         o_emergency_close,
	output logic                         o_barrier_open_cmd,
	output logic                         o_barrier_close_cmd,
	output logic [NUM_STATIONS-1:0]      o_station_ind,
	output logic                         o_span_inhibit
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		bms_sig_t                sig;
		bms_mode_t               mode_prev;
		logic [7:0]              tmr;
		logic                    delay_run;
		logic [7:0]              horn_cnt;
		logic [7:0]              horn_ticks;
		logic                    active;
		logic                    close_req;
		logic [NUM_STATIONS-1:0] pressed;
		logic                    wigwag;
		logic [3:0]              ctrl;
		logic                    close_out;
		logic                    open_cmd;
		logic                    close_cmd;
		logic                    yel;
		logic                    red_a;
		logic                    red_b;
		logic                    pave;
		logic [NUM_STATIONS-1:0] ind;
		logic                    span_out;
		logic [31:0]             rdata;
	} bms_state_t;

	bms_state_t r_reg;
	bms_state_t r_next;

	logic tick;
	logic flash;

	// ************************************************************
	// Timebase
	// ************************************************************
	bms_tick_gen #(
		.TICK_DIV  (TICK_DIV),
		.FLASH_DIV (FLASH_DIV)
	) u_tick (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.o_tick  (tick),
		.o_flash (flash)
	);

	// Unused selector code 3 falls back to local, which never arms the emergency close
	function automatic bms_mode_t decode_mode(input logic [1:0] sel);
		case (sel)
			2'h0: decode_mode = MODE_EMERG;
			2'h1: decode_mode = MODE_TEST;
			default: decode_mode = MODE_LOCAL;
		endcase
	endfunction

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		bms_mode_t mode;
		logic      multi_local;
		logic      armed;
		logic      press;
		logic      all_open;
		logic      move_ok;
		logic      dets_clear;
		mode        = decode_mode(i_mode_sel);
		multi_local = (mode == MODE_LOCAL) && r_reg.ctrl[CTRL_MULTI_BAR];
		armed       = (mode == MODE_EMERG) && !i_span_inhibit;
		press       = |i_emergency_close_station;
		all_open    = &i_barrier_open;
		dets_clear  = !i_detector_entry && !i_detector_exit;
		move_ok     = 1'b0;
		r_next      = r_reg;
		r_next.rdata = '0;
		r_next.mode_prev = mode;

		// Timer runs on the slow tick only
		if (tick && (r_reg.tmr != 8'h0)) begin
			r_next.tmr = r_reg.tmr - 8'h1;
		end
		if (tick && (r_reg.horn_cnt != 8'h0)) begin
			r_next.horn_cnt = r_reg.horn_cnt - 8'h1;
		end

		// Expiry of the shared 2 s timer ends yellow and the close delay
		if (r_reg.tmr == 8'h0) begin
			if (r_reg.sig == SIG_YELLOW) begin
				r_next.sig = SIG_RED;
			end
			if (r_reg.delay_run) begin
				r_next.delay_run = 1'b0;
				r_next.close_req = 1'b1;
			end
		end

		// Entry to test, or to local without the multi-barrier bit, starts the beacon cycle from dark
		if ((mode != r_reg.mode_prev) && (r_reg.sig == SIG_DARK) &&
			((mode == MODE_TEST) || ((mode == MODE_LOCAL) && !r_reg.ctrl[CTRL_MULTI_BAR]))) begin
			r_next.sig = SIG_YELLOW;
			r_next.tmr = 8'(YELLOW_TICKS);
		end

		// Keyed reset drops the latch; the wig-wags only if so configured
		if (i_emergency_latch_clear) begin
			r_next.active    = 1'b0;
			r_next.close_req = 1'b0;
			r_next.delay_run = 1'b0;
			r_next.pressed   = '0;
			if (r_reg.ctrl[CTRL_RST_WIGWAG]) begin
				r_next.wigwag = 1'b0;
			end
		end

		// Activation placed after the clear so a new press is not lost
		if (armed && press && !r_reg.active) begin
			r_next.active    = 1'b1;
			r_next.pressed   = i_emergency_close_station;
			r_next.wigwag    = 1'b1;
			r_next.horn_cnt  = r_reg.horn_ticks;
			r_next.delay_run = 1'b1;
			r_next.tmr       = 8'(CLOSE_DELAY_TICKS);
			if (r_reg.sig == SIG_DARK) begin
				r_next.sig = SIG_YELLOW;
			end
		end else if (r_reg.active && press) begin
			r_next.pressed = r_reg.pressed | i_emergency_close_station;
		end

		// Return to dark needs every barrier open and the selector in emergency
		if ((r_reg.sig == SIG_RED) && (mode == MODE_EMERG) && all_open && !r_reg.active) begin
			r_next.sig    = SIG_DARK;
			r_next.wigwag = 1'b0;
		end

		// Optional wig-wags in test or in single-barrier local
		if (r_reg.ctrl[CTRL_WIGWAG_TL] && (mode != MODE_EMERG) && (r_reg.sig != SIG_DARK) && !multi_local) begin
			r_next.wigwag = 1'b1;
		end

		// Emergency close held only while both detectors are clear
		r_next.close_out = r_next.close_req && dets_clear;

		// Button gating by mode; emergency lockout overrides everything
		move_ok = !r_reg.active &&
			(((mode == MODE_TEST) && (r_reg.sig == SIG_RED)) ||
			((mode == MODE_LOCAL) && i_local_key &&
			(r_reg.ctrl[CTRL_MULTI_BAR] || (r_reg.sig == SIG_RED))));
		case (mode)
			MODE_TEST: begin
				r_next.open_cmd  = move_ok && i_master_open;
				r_next.close_cmd = move_ok && i_master_close;
			end
			MODE_LOCAL: begin
				r_next.open_cmd  = move_ok && i_local_open;
				r_next.close_cmd = move_ok && i_local_close;
			end
			default: begin
				r_next.open_cmd  = 1'b0;
				r_next.close_cmd = 1'b0;
			end
		endcase

		// Lamp drive from the signal state and the flash phase
		r_next.yel   = (r_next.sig == SIG_YELLOW);
		r_next.red_a = (r_next.sig == SIG_RED) && flash;
		r_next.red_b = (r_next.sig == SIG_RED) && !flash;
		r_next.pave  = (r_next.sig == SIG_RED) && flash && !multi_local;
		r_next.ind   = '0;
		if (r_next.active) begin
			r_next.ind = ~r_next.pressed | (r_next.pressed & {NUM_STATIONS{flash}});
		end
		r_next.span_out = r_reg.ctrl[CTRL_SPAN_BOTH] && (mode != MODE_EMERG);

		// Register writes
		if (i_wr) begin
			case (i_addr)
				ADDR_CTRL: r_next.ctrl = i_wdata[3:0];
				ADDR_HORN: r_next.horn_ticks = i_wdata[7:0];
				default: ;
			endcase
		end

		// Register reads, data one cycle later; unmapped reads zero
		if (i_rd) begin
			case (i_addr)
				ADDR_CTRL: r_next.rdata = {28'h0, r_reg.ctrl};
				ADDR_HORN: r_next.rdata = {24'h0, r_reg.horn_ticks};
				ADDR_STATUS: begin
					r_next.rdata[STAT_SIG_LSB +: 2]  = r_reg.sig;
					r_next.rdata[STAT_ACTIVE]        = r_reg.active;
					r_next.rdata[STAT_CLOSE_REQ]     = r_reg.close_req;
					r_next.rdata[STAT_MODE_LSB +: 2] = r_reg.mode_prev;
					r_next.rdata[STAT_HORN]          = (r_reg.horn_cnt != 8'h0);
				end
				default: r_next.rdata = '0;
			endcase
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r_reg            <= '0;
			r_reg.horn_ticks <= HORN_TICKS_RST;
			r_reg.ctrl       <= CTRL_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign o_rdata             = r_reg.rdata;
	assign o_beacon_yellow     = r_reg.yel;
	assign o_beacon_red_a      = r_reg.red_a;
	assign o_beacon_red_b      = r_reg.red_b;
	assign o_pavement_red      = r_reg.pave;
	assign o_wigwag            = r_reg.wigwag;
	assign o_horn              = (r_reg.horn_cnt != 8'h0);
	assign o_emergency_close   = r_reg.close_out;
	assign o_barrier_open_cmd  = r_reg.open_cmd;
	assign o_barrier_close_cmd = r_reg.close_cmd;
	assign o_station_ind       = r_reg.ind;
	assign o_span_inhibit      = r_reg.span_out;

endmodule

`default_nettype wire

// >>> design/bms_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none

module bms_tick_gen
	import bms_pkg::*;
#(
	parameter int unsigned TICK_DIV  = TICK_CYCLES,
	parameter int unsigned FLASH_DIV = FLASH_TICKS
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	output logic      o_tick,
	output logic      o_flash
);

	typedef struct packed {
		logic [31:0] div;
		logic [15:0] half;
		logic        tick;
		logic        flash;
	} bms_tick_st_t;

	bms_tick_st_t r_reg;
	bms_tick_st_t r_next;

	// Divider makes the slow tick; flash toggles every FLASH_DIV ticks
	always_comb begin
		r_next = r_reg;
		r_next.tick = 1'b0;
		if (r_reg.div >= 32'(TICK_DIV - 1)) begin
			r_next.div = '0;
			r_next.tick = 1'b1;
		end else begin
			r_next.div = r_reg.div + 32'h1;
		end
		if (r_reg.tick) begin
			if (r_reg.half >= 16'(FLASH_DIV - 1)) begin
				r_next.half = '0;
				r_next.flash = ~r_reg.flash;
			end else begin
				r_next.half = r_reg.half + 16'h1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_tick  = r_reg.tick;
	assign o_flash = r_reg.flash;

endmodule

`default_nettype wire

// >>> tb/bms_barrier_model.sv
`timescale 1ns/1ps
`default_nettype none

// ********************
// Barrier power unit
// ********************
module bms_barrier_model #(
	parameter int unsigned TRAVEL = 8
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_emergency_close,
	input  wire logic i_close_cmd,
	input  wire logic i_open_cmd,
	input  wire logic i_slow,
	output logic      o_barrier_open
);
	int   cnt_reg;
	logic target_reg;
	// Reports open only at the end of travel; slow units take four times longer
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_barrier_open <= 1'b1;
			target_reg <= 1'b1;
			cnt_reg <= 0;
		end else if ((i_emergency_close || i_close_cmd) && target_reg) begin
			target_reg <= 1'b0;
			o_barrier_open <= 1'b0;
			cnt_reg <= i_slow ? 4 * TRAVEL : TRAVEL;
		end else if (i_open_cmd && !target_reg) begin
			target_reg <= 1'b1;
			cnt_reg <= i_slow ? 4 * TRAVEL : TRAVEL;
		end else if (cnt_reg != 0) begin
			cnt_reg <= cnt_reg - 1;
		end else begin
			o_barrier_open <= target_reg;
		end
	end
endmodule
`default_nettype wire

// >>> tb/bms_sequencer_sva.sv
`timescale 1ns/1ps
`default_nettype none

// ********************
// Port checker
// ********************
module bms_sequencer_sva
	import bms_pkg::*;
#(
	parameter int unsigned NUM_STATIONS = 4,
	parameter int unsigned TICK_DIV     = TICK_CYCLES
) (
	input wire logic                    i_clk,
	input wire logic                    i_rst_n,
	input wire logic                    i_rd,
	input wire logic [31:0]             o_rdata,
	input wire logic [1:0]              i_mode_sel,
	input wire logic [NUM_STATIONS-1:0] i_emergency_close_station,
	input wire logic                    i_master_open,
	input wire logic                    i_local_key,
	input wire logic                    i_local_open,
	input wire logic                    i_detector_entry,
	input wire logic                    i_detector_exit,
	input wire logic                    i_span_inhibit,
	input wire logic                    o_beacon_yellow,
	input wire logic                    o_beacon_red_a,
	input wire logic                    o_beacon_red_b,
	input wire logic                    o_pavement_red,
	input wire logic                    o_wigwag,
	input wire logic                    o_horn,
	input wire logic                    o_emergency_close,
	input wire logic                    o_barrier_open_cmd,
	input wire logic                    o_barrier_close_cmd,
	input wire logic [NUM_STATIONS-1:0] o_station_ind,
	input wire logic                    o_span_inhibit
);
	// Yellow lasts too long for a repetition, so it is counted; one tick of slop
	localparam int YEL_MIN = (YELLOW_TICKS - 1) * TICK_DIV;
	localparam int YEL_MAX = (YELLOW_TICKS + 1) * TICK_DIV + 2;
	int   ycnt_reg;
	logic perm_reg;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ycnt_reg <= 0;
			perm_reg <= 1'b0;
		end else begin
			ycnt_reg <= o_beacon_yellow ? ycnt_reg + 1 : 0;
			perm_reg <= (i_mode_sel == 2'h1 && i_master_open) || (i_mode_sel[1] && i_local_key && i_local_open);
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_press;
		i_mode_sel == 2'h0 && !i_span_inhibit && (|i_emergency_close_station) && !o_wigwag;
	endsequence
	sequence s_red;
		o_beacon_red_a || o_beacon_red_b;
	endsequence

	property p_emerg_ignore;
		i_mode_sel == 2'h0 |=> !o_barrier_open_cmd && !o_barrier_close_cmd;
	endproperty
	a_emerg_ignore: assert property (p_emerg_ignore) else $error("panel button passed");
	property p_open_cause;
		o_barrier_open_cmd |-> perm_reg;
	endproperty
	a_open_cause: assert property (p_open_cause) else $error("open without leave");
	property p_warn_now;
		s_press |=> o_wigwag && o_horn;
	endproperty
	a_warn_now: assert property (p_warn_now) else $error("warning late");
	property p_ind;
		s_press |=> (o_station_ind | $past(i_emergency_close_station)) == '1;
	endproperty
	a_ind: assert property (p_ind) else $error("indicator not steady");
	property p_red_alt;
		s_red |-> o_beacon_red_a != o_beacon_red_b && !o_beacon_yellow;
	endproperty
	a_red_alt: assert property (p_red_alt) else $error("red lamps not alternate");
	property p_yel_len;
		$fell(o_beacon_yellow) |-> ycnt_reg >= YEL_MIN && ycnt_reg <= YEL_MAX;
	endproperty
	a_yel_len: assert property (p_yel_len) else $error("yellow length wrong");
	property p_pave;
		o_pavement_red |-> s_red;
	endproperty
	a_pave: assert property (p_pave) else $error("pavement lit off red");
	property p_close_clear;
		o_emergency_close |-> !$past(i_detector_entry) && !$past(i_detector_exit) && !o_beacon_yellow;
	endproperty
	a_close_clear: assert property (p_close_clear) else $error("close on occupied");
	property p_span;
		o_span_inhibit |-> $past(i_mode_sel) != 2'h0;
	endproperty
	a_span: assert property (p_span) else $error("span inhibit in emergency");
	property p_rdata_idle;
		!$past(i_rd) |-> o_rdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
endmodule

bind bms_sequencer bms_sequencer_sva #(
	.NUM_STATIONS(NUM_STATIONS),
	.TICK_DIV    (TICK_DIV)
) i_bms_sequencer_sva (.*);
`default_nettype wire

// >>> tb/bms_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module bms_sequencer_tb
	import bms_pkg::*;
;
	logic        i_clk, i_rst_n, i_wr, i_rd, i_emergency_latch_clear, i_master_open, i_master_close, slow;
	logic        i_local_key, i_local_open, i_local_close, i_detector_entry, i_detector_exit, i_span_inhibit;
	logic [3:0]  i_addr, i_emergency_close_station, o_station_ind;
	logic [31:0] i_wdata, o_rdata;
	logic [1:0]  i_mode_sel, pv;
	logic [0:0]  i_barrier_open;
	logic        o_beacon_yellow, o_beacon_red_a, o_beacon_red_b, o_pavement_red, o_wigwag, o_horn;
	logic        o_emergency_close, o_barrier_open_cmd, o_barrier_close_cmd, o_span_inhibit;
	int          fail_count, checked;

	// Short tick (10 cycles) and flash (2 ticks) keep the run brief
	bms_sequencer #(.TICK_DIV(10), .FLASH_DIV(2)) i_bms_sequencer (.*);
	bms_barrier_model i_bms_barrier_model (
		.i_clk            (i_clk),
		.i_rst_n          (i_rst_n),
		.i_emergency_close(o_emergency_close),
		.i_close_cmd      (o_barrier_close_cmd),
		.i_open_cmd       (o_barrier_open_cmd),
		.i_slow           (slow),
		.o_barrier_open   (i_barrier_open[0])
	);

	// ********************
	// Tasks
	// ********************
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, e);
	endtask
	task automatic test_done;
		if (fail_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Clock and hang guard
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	initial begin
		#1_000_000;
		fail_count++;
		test_done();
	end

	// ********************
	// Scenarios
	// ********************
	initial begin
		{i_wr, i_rd, i_emergency_latch_clear, i_master_open, i_master_close, i_local_key, slow} = '0;
		{i_local_open, i_local_close, i_detector_entry, i_detector_exit, i_span_inhibit} = '0;
		{i_addr, i_wdata, i_mode_sel, i_emergency_close_station} = '0;
		i_rst_n = 1'b0;
		fail_count = 0;
		checked = 0;
		repeat (5) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(ADDR_CTRL, 32'(CTRL_RST));
		rd(ADDR_HORN, 32'(HORN_TICKS_RST));
		wr(ADDR_STATUS, 32'hFF);
		rd(ADDR_STATUS, 32'h0);
		rd(4'hC, 32'h0);
		wr(ADDR_HORN, 32'h1E);
		rd(ADDR_HORN, 32'h1E);
		// Emergency press with a car on the entry loop
		@(posedge i_clk);
		i_master_open <= 1'b1;
		i_detector_entry <= 1'b1;
		wt(3);
		chk({o_barrier_open_cmd, o_beacon_yellow, o_beacon_red_a, o_beacon_red_b, o_pavement_red}, 0);
		@(posedge i_clk);
		i_master_open <= 1'b0;
		i_emergency_close_station <= 4'h2;
		wt(1);
		chk({o_wigwag, o_horn, o_beacon_yellow}, 3'h7);
		chk(o_station_ind | 4'h2, 4'hF);
		@(posedge i_clk);
		i_emergency_close_station <= 4'h0;
		wt(170);
		chk({o_beacon_yellow, o_beacon_red_a | o_beacon_red_b, o_emergency_close}, 3'h4);
		wt(45);
		chk({o_beacon_yellow, o_beacon_red_a ^ o_beacon_red_b, o_emergency_close}, 3'h2);
		rd(ADDR_STATUS, 32'h4E);
		pv = 2'h0;
		repeat (40) begin
			wt(1);
			pv = pv | {o_pavement_red, !o_pavement_red};
		end
		chk(pv, 2'h3);
		wt(20);
		chk(o_horn, 1'b1);
		wt(45);
		chk(o_horn, 1'b0);
		@(posedge i_clk);
		i_detector_entry <= 1'b0;
		wt(3);
		chk(o_emergency_close, 1'b1);
		// Lockout until the keyed clear, barrier closed beforehand
		@(posedge i_clk);
		i_mode_sel <= 2'h1;
		i_master_open <= 1'b1;
		wt(12);
		chk(o_barrier_open_cmd, 1'b0);
		@(posedge i_clk);
		i_emergency_latch_clear <= 1'b1;
		@(posedge i_clk);
		i_emergency_latch_clear <= 1'b0;
		wt(3);
		chk({o_wigwag, o_emergency_close, o_barrier_open_cmd}, 3'h1);
		@(posedge i_clk);
		i_master_open <= 1'b0;
		i_mode_sel <= 2'h0;
		wt(1);
		chk(o_beacon_red_a | o_beacon_red_b, 1'b1);
		wt(25);
		chk({o_beacon_yellow, o_beacon_red_a, o_beacon_red_b, o_pavement_red}, 0);
		// Test mode from dark, slow barrier
		@(posedge i_clk);
		slow <= 1'b1;
		i_mode_sel <= 2'h1;
		i_master_close <= 1'b1;
		i_local_open <= 1'b1;
		i_emergency_close_station <= 4'h1;
		wt(150);
		chk({o_beacon_yellow, o_wigwag, o_horn, o_barrier_close_cmd}, 4'h8);
		wt(70);
		chk({o_beacon_yellow, o_beacon_red_a | o_beacon_red_b, o_wigwag, o_barrier_close_cmd}, 4'h5);
		@(posedge i_clk);
		{i_master_close, i_local_open, i_emergency_close_station} <= '0;
		i_mode_sel <= 2'h0;
		wt(60);
		chk(o_beacon_red_a | o_beacon_red_b, 1'b1);
		// Local panel opens the closed barrier only with the key
		@(posedge i_clk);
		i_mode_sel <= 2'h2;
		i_master_open <= 1'b1;
		wt(3);
		chk(o_barrier_open_cmd, 1'b0);
		@(posedge i_clk);
		i_local_key <= 1'b1;
		i_local_open <= 1'b1;
		wt(3);
		chk(o_barrier_open_cmd, 1'b1);
		@(posedge i_clk);
		{i_master_open, i_local_open} <= '0;
		i_mode_sel <= 2'h0;
		wt(45);
		chk({o_beacon_red_a, o_beacon_red_b, o_pavement_red}, 0);
		// Local mode from dark, single barrier
		@(posedge i_clk);
		i_mode_sel <= 2'h2;
		i_local_open <= 1'b1;
		wt(100);
		chk({o_beacon_yellow, o_barrier_open_cmd, o_wigwag}, 3'h4);
		wt(120);
		chk({o_beacon_yellow, o_beacon_red_a | o_beacon_red_b, o_barrier_open_cmd}, 3'h3);
		@(posedge i_clk);
		{i_local_open, i_local_key} <= '0;
		i_mode_sel <= 2'h0;
		wt(5);
		chk({o_beacon_red_a, o_beacon_red_b}, 0);
		// Several barriers and a shared span
		wr(ADDR_CTRL, 32'hD);
		@(posedge i_clk);
		i_mode_sel <= 2'h2;
		wt(40);
		chk({o_beacon_yellow, o_beacon_red_a, o_pavement_red, o_wigwag, o_span_inhibit}, 5'h01);
		@(posedge i_clk);
		i_mode_sel <= 2'h0;
		i_span_inhibit <= 1'b1;
		i_emergency_close_station <= 4'h8;
		wt(5);
		chk({o_wigwag, o_horn}, 2'h0);
		test_done();
	end
endmodule
`default_nettype wire
